/* swpin_pkg.sv */
// Constants and types of the switch pin strap and alternate-function block
package swpin_pkg;

  // ---------------------------------------------------------------
  // Clock and bus rates
  // ---------------------------------------------------------------
  localparam int SYS_HZ      = 50_000_000;
  localparam int BUS_SLOW_HZ = 100_000;
  localparam int BUS_FAST_HZ = 400_000;
  // Quarter bit times are least times, so round up
  localparam int Q_SLOW_CYC  = (SYS_HZ + 4*BUS_SLOW_HZ - 1) / (4*BUS_SLOW_HZ);
  localparam int Q_FAST_CYC  = (SYS_HZ + 4*BUS_FAST_HZ - 1) / (4*BUS_FAST_HZ);
  localparam logic [7:0] Q_SLOW = 8'(Q_SLOW_CYC);
  localparam logic [7:0] Q_FAST = 8'(Q_FAST_CYC);

  localparam logic [7:0] REF_MHZ_LO = 8'h64;
  localparam logic [7:0] REF_MHZ_HI = 8'h7D;
  localparam logic [2:0] STRAP_HOLD = 3'h6;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_STRAP    = 8'h00;
  localparam logic [7:0] REG_PORTCFG  = 8'h04;
  localparam logic [7:0] REG_GPIO_IN  = 8'h08;
  localparam logic [7:0] REG_GPIO_OUT = 8'h0C;
  localparam logic [7:0] REG_GPIO_DIR = 8'h10;
  localparam logic [7:0] REG_GPIO_ALT = 8'h14;
  localparam logic [7:0] REG_PORT_RST = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h20;
  localparam logic [7:0] REG_IRQ_EN   = 8'h24;
  localparam logic [7:0] REG_MCMD     = 8'h28;
  localparam logic [7:0] REG_MSTAT    = 8'h2C;

  // ---------------------------------------------------------------
  // Fields, pin roles and fixed address bits
  // ---------------------------------------------------------------
  localparam int IRQ_W         = 5;
  localparam int IRQ_EXP0      = 0;
  localparam int IRQ_EXP2      = 1;
  localparam int IRQ_MDONE     = 2;
  localparam int IRQ_MNACK     = 3;
  localparam int IRQ_SADDR     = 4;
  localparam int MCMD_READ     = 8;
  localparam int MCMD_EXP      = 9;
  localparam logic [7:0] ALT_MASK     = 8'h97;
  localparam logic [7:0] ALT_OUT_MASK = 8'h83;
  localparam logic [3:0] UP_PORT   = 4'h0;
  localparam logic [3:0] DN_PORT_B = 4'h2;
  localparam logic [3:0] DN_PORT_C = 4'h4;
  localparam logic [3:0] LANES     = 4'h8;
  localparam logic [1:0] EE_HI     = 2'h2;
  localparam logic       EE_B0     = 1'b0;
  localparam logic       SLV_B6    = 1'b1;
  localparam logic       SLV_B4    = 1'b1;
  localparam logic       SLV_B0    = 1'b0;
  localparam logic [4:0] FRAME_LAST = 5'h11;

  typedef enum {M_IDLE, M_START, M_BITS, M_STOP} swpin_mst_t;
  typedef enum {S_IDLE, S_ADDR, S_ACK, S_WAIT} swpin_slv_t;

endpackage

/* swpin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module swpin_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // A bit moves only once stages two and three agree
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

/* swpin_top.sv */
// Strap capture, SMBus pins and general purpose pin multiplexing
//
// How it works
// (RL1) Names ending in _n are asserted low, everything else high.
// (RL2) The frequency strap picks a 100 MHz (0) or 125 MHz (1) reference.
// (RL3) The slow strap runs the master bus at 100 KHz, else 400 KHz.
// (RL4) Nothing in software can override the master bus speed strap.
// (RL5) The master bus clock toggles only during an access, else idles.
// (RL6) The EEPROM address takes bits 4 to 1 from the master address strap.
// (RL7) The slave bus acks only its strap address, bits 5 and 3 to 1.
// (RL8) All eight pins work as plain GPIO; pins 3, 5 and 6 have no alt.
// (RL9) Pin 0 in alt mode drives the active-low port 2 reset.
// (RL10) Pin 1 in alt mode drives the active-low port 4 reset.
// (RL11) Pin 2 in alt mode samples the active-low expander 0 interrupt.
// (RL12) Pin 4 in alt mode samples the active-low expander 2 interrupt.
// (RL13) Pin 7 in alt mode drives the active-low general purpose event.
// (RL14) The downstream shared-clock strap marks downstream clocks shared.
// (RL15) The upstream shared-clock strap marks the upstream clock shared.
// (RL16) Port 0 is upstream, ports 2 and 4 downstream, eight lanes each.
// (RL17) Straps are taken around reset and then held for good.
`timescale 1ns/1ns
module swpin_top
  import swpin_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  input  wire logic        ref_clock_freq_select,
  input  wire logic        master_bus_slow_strap,
  input  wire logic [3:0]  eeprom_addr_strap,
  input  wire logic [3:0]  slave_addr_strap,
  input  wire logic        shared_clock_down_strap,
  input  wire logic        shared_clock_up_strap,
  output logic             ref_clock_is_125,
  output logic      [7:0]  ref_clock_mhz,
  output logic             shared_clock_down,
  output logic             shared_clock_up,
  input  wire logic        master_bus_clock_in,
  output logic             master_bus_clock_out,
  output logic             master_bus_clock_oe_n,
  input  wire logic        master_bus_data_in,
  output logic             master_bus_data_out,
  output logic             master_bus_data_oe_n,
  input  wire logic        slave_bus_clock_in,
  output logic             slave_bus_clock_out,
  output logic             slave_bus_clock_oe_n,
  input  wire logic        slave_bus_data_in,
  output logic             slave_bus_data_out,
  output logic             slave_bus_data_oe_n,
  input  wire logic [7:0]  gpio_in,
  output logic      [7:0]  gpio_out,
  output logic      [7:0]  gpio_oe_n
);

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [11:0] pin_s;
  logic [11:0] strap_s;
  logic [7:0]  gp_s;
  logic        mbc_s;
  logic        mbd_s;
  logic        sbc_s;
  logic        sbd_s;

  // Open-drain lines idle high, so start from one to avoid false edges
  swpin_sync #(.W(12), .RST_VAL(12'hFFF)) u_pin_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     ({gpio_in, master_bus_clock_in, master_bus_data_in,
                slave_bus_clock_in, slave_bus_data_in}),
    .dout    (pin_s)
  );

  swpin_sync #(.W(12), .RST_VAL(12'h000)) u_strap_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     ({ref_clock_freq_select, master_bus_slow_strap,
                shared_clock_down_strap, shared_clock_up_strap,
                eeprom_addr_strap, slave_addr_strap}),
    .dout    (strap_s)
  );

  assign gp_s  = pin_s[11:4];
  assign mbc_s = pin_s[3];
  assign mbd_s = pin_s[2];
  assign sbc_s = pin_s[1];
  assign sbd_s = pin_s[0];

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  logic       lock_reg;
  logic [2:0] hold_cnt_reg;
  logic       ref125_reg;
  logic       slow_reg;
  logic       cdn_reg;
  logic       cup_reg;
  logic [3:0] ee_strap_reg;
  logic [3:0] slv_strap_reg;
  logic [6:0] ee_addr7;
  logic [6:0] slv_addr7;

  // Async reset may only load constants, so the window runs after release
  // (RL17) capture then hold
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg      <= 1'b0;
      hold_cnt_reg  <= 3'h0;
      ref125_reg    <= 1'b0;
      slow_reg      <= 1'b0;
      cdn_reg       <= 1'b0;
      cup_reg       <= 1'b0;
      ee_strap_reg  <= 4'h0;
      slv_strap_reg <= 4'h0;
    end else if (!lock_reg) begin
      ref125_reg    <= strap_s[11];
      slow_reg      <= strap_s[10];
      cdn_reg       <= strap_s[9];
      cup_reg       <= strap_s[8];
      ee_strap_reg  <= strap_s[7:4];
      slv_strap_reg <= strap_s[3:0];
      hold_cnt_reg  <= hold_cnt_reg + 3'h1;
      lock_reg      <= (hold_cnt_reg == STRAP_HOLD);
    end
  end

  // (RL2) reference frequency
  assign ref_clock_is_125 = ref125_reg;
  assign ref_clock_mhz    = ref125_reg ? REF_MHZ_HI : REF_MHZ_LO;
  // (RL14) downstream shared clock
  assign shared_clock_down = cdn_reg;
  // (RL15) upstream shared clock
  assign shared_clock_up   = cup_reg;
  // (RL6) EEPROM address bits
  assign ee_addr7  = {EE_HI, ee_strap_reg, EE_B0};
  // (RL7) slave address bits
  assign slv_addr7 = {SLV_B6, slv_strap_reg[3], SLV_B4,
                      slv_strap_reg[2:0], SLV_B0};

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic [7:0]       gp_out_reg;
  logic [7:0]       gp_dir_reg;
  logic [7:0]       gp_alt_reg;
  logic [1:0]       port_rst_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic             wr_hit_mcmd;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gp_out_reg   <= 8'h00;
      gp_dir_reg   <= 8'h00;
      gp_alt_reg   <= 8'h00;
      port_rst_reg <= 2'h0;
      irq_en_reg   <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_GPIO_OUT: gp_out_reg   <= reg_wdata[7:0];
        REG_GPIO_DIR: gp_dir_reg   <= reg_wdata[7:0];
        // (RL8) alt bits exist only on pins with a second role
        REG_GPIO_ALT: gp_alt_reg   <= reg_wdata[7:0] & ALT_MASK;
        REG_PORT_RST: port_rst_reg <= reg_wdata[1:0];
        REG_IRQ_EN:   irq_en_reg   <= reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign wr_hit_mcmd = reg_wr && (reg_addr == REG_MCMD);
  assign irq_clr = (reg_wr && reg_addr == REG_IRQ_CLR) ?
                   reg_wdata[IRQ_W-1:0] : '0;

  // Set beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      irq          <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ---------------------------------------------------------------
  // Master bus engine
  // ---------------------------------------------------------------
  swpin_mst_t  mst_st;
  logic [7:0]  div_cnt_reg;
  logic [7:0]  q_lim;
  logic        q_tick;
  logic [1:0]  ph_reg;
  logic [4:0]  slot_reg;
  logic [17:0] shift_reg;
  logic        rd_mode_reg;
  logic        nack_reg;
  logic [7:0]  rx_reg;
  logic        mdone_reg;
  logic        mscl_oe_n_reg;
  logic        msda_oe_n_reg;
  logic [6:0]  tgt_addr7;

  // (RL3) strap-only speed
  // (RL4) no register path feeds q_lim
  assign q_lim  = slow_reg ? Q_SLOW : Q_FAST;
  assign q_tick = (mst_st != M_IDLE) && (div_cnt_reg == q_lim - 8'h01);
  assign tgt_addr7 = reg_wdata[MCMD_EXP] ? reg_wdata[22:16] : ee_addr7;

  // (RL5) divider runs only while busy
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= 8'h00;
    end else if (mst_st == M_IDLE || q_tick) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // Each bit spends four quarter ticks: set data, rise, sample, fall
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mst_st        <= M_IDLE;
      ph_reg        <= 2'h0;
      slot_reg      <= 5'h00;
      shift_reg     <= '0;
      rd_mode_reg   <= 1'b0;
      nack_reg      <= 1'b0;
      rx_reg        <= 8'h00;
      mdone_reg     <= 1'b0;
      mscl_oe_n_reg <= 1'b1;
      msda_oe_n_reg <= 1'b1;
    end else begin
      mdone_reg <= 1'b0;
      unique case (mst_st)
        M_IDLE: begin
          if (wr_hit_mcmd && lock_reg) begin
            mst_st      <= M_START;
            ph_reg      <= 2'h0;
            slot_reg    <= 5'h00;
            nack_reg    <= 1'b0;
            rd_mode_reg <= reg_wdata[MCMD_READ];
            shift_reg   <= {tgt_addr7, reg_wdata[MCMD_READ], 1'b1,
                            reg_wdata[MCMD_READ] ? 8'hFF : reg_wdata[7:0],
                            1'b1};
          end
        end
        M_START: begin
          if (q_tick) begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h1) msda_oe_n_reg <= 1'b0;
            if (ph_reg == 2'h2) mscl_oe_n_reg <= 1'b0;
            if (ph_reg == 2'h3) mst_st <= M_BITS;
          end
        end
        M_BITS: begin
          if (q_tick) begin
            ph_reg <= ph_reg + 2'h1;
            unique case (ph_reg)
              2'h0: msda_oe_n_reg <= shift_reg[17];
              2'h1: mscl_oe_n_reg <= 1'b1;
              2'h2: begin
                if (slot_reg == 5'h08 ||
                    (slot_reg == FRAME_LAST && !rd_mode_reg)) begin
                  nack_reg <= nack_reg | mbd_s;
                end
                if (rd_mode_reg && slot_reg > 5'h08 &&
                    slot_reg < FRAME_LAST) begin
                  rx_reg <= {rx_reg[6:0], mbd_s};
                end
              end
              2'h3: begin
                mscl_oe_n_reg <= 1'b0;
                shift_reg     <= {shift_reg[16:0], 1'b1};
                slot_reg      <= slot_reg + 5'h01;
                if (slot_reg == FRAME_LAST) mst_st <= M_STOP;
              end
            endcase
          end
        end
        M_STOP: begin
          if (q_tick) begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0) msda_oe_n_reg <= 1'b0;
            if (ph_reg == 2'h1) mscl_oe_n_reg <= 1'b1;
            if (ph_reg == 2'h2) msda_oe_n_reg <= 1'b1;
            if (ph_reg == 2'h3) begin
              mst_st    <= M_IDLE;
              mdone_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign master_bus_clock_out  = 1'b0;
  assign master_bus_clock_oe_n = mscl_oe_n_reg;
  assign master_bus_data_out   = 1'b0;
  assign master_bus_data_oe_n  = msda_oe_n_reg;

  // ---------------------------------------------------------------
  // Slave address matcher
  // ---------------------------------------------------------------
  // Only the address phase is answered; later bytes are not acked
  swpin_slv_t slv_st;
  logic       sbc_q;
  logic       sbd_q;
  logic [7:0] sh_reg;
  logic [3:0] bit_cnt_reg;
  logic       ssda_oe_n_reg;
  logic       saddr_hit_reg;
  logic       s_start;
  logic       s_stop;

  assign s_start = sbc_s & sbc_q & fell(sbd_q, sbd_s);
  assign s_stop  = sbc_s & sbc_q & fell(sbd_s, sbd_q);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      slv_st        <= S_IDLE;
      sbc_q         <= 1'b1;
      sbd_q         <= 1'b1;
      sh_reg        <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      ssda_oe_n_reg <= 1'b1;
      saddr_hit_reg <= 1'b0;
    end else begin
      sbc_q         <= sbc_s;
      sbd_q         <= sbd_s;
      saddr_hit_reg <= 1'b0;
      if (!lock_reg || s_stop) begin
        slv_st        <= S_IDLE;
        ssda_oe_n_reg <= 1'b1;
      end else if (s_start) begin
        slv_st        <= S_ADDR;
        bit_cnt_reg   <= 4'h0;
        ssda_oe_n_reg <= 1'b1;
      end else begin
        unique case (slv_st)
          S_IDLE, S_WAIT: ;
          S_ADDR: begin
            if (sbc_s && !sbc_q) begin
              sh_reg      <= {sh_reg[6:0], sbd_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (fell(sbc_q, sbc_s) && bit_cnt_reg == 4'h8) begin
              // (RL7) ack own address only
              if (sh_reg[7:1] == slv_addr7) begin
                ssda_oe_n_reg <= 1'b0;
                saddr_hit_reg <= 1'b1;
                slv_st        <= S_ACK;
              end else begin
                slv_st        <= S_WAIT;
              end
            end
          end
          S_ACK: begin
            if (fell(sbc_q, sbc_s)) begin
              ssda_oe_n_reg <= 1'b1;
              slv_st        <= S_WAIT;
            end
          end
        endcase
      end
    end
  end

  // The slave never stretches the clock
  assign slave_bus_clock_out  = 1'b0;
  assign slave_bus_clock_oe_n = 1'b1;
  assign slave_bus_data_out   = 1'b0;
  assign slave_bus_data_oe_n  = ssda_oe_n_reg;

  // ---------------------------------------------------------------
  // General purpose pins
  // ---------------------------------------------------------------
  logic [7:0] gp_q;
  logic [7:0] alt_val;

  // (RL1) low-true: (RL9) port 2, (RL10) port 4 reset, (RL13) event
  assign alt_val = {~irq, 5'h00, ~port_rst_reg[1], ~port_rst_reg[0]};

  // (RL8) per-pin direction or alternate role
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          gpio_out[gi]  <= 1'b0;
          gpio_oe_n[gi] <= 1'b1;
        end else if (gp_alt_reg[gi]) begin
          gpio_out[gi]  <= alt_val[gi];
          gpio_oe_n[gi] <= ~ALT_OUT_MASK[gi];
        end else begin
          gpio_out[gi]  <= gp_out_reg[gi];
          gpio_oe_n[gi] <= ~gp_dir_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gp_q <= 8'hFF;
    end else begin
      gp_q <= gp_s;
    end
  end

  // (RL11) expander 0 interrupt, falling edge
  assign irq_set[IRQ_EXP0]  = gp_alt_reg[2] & fell(gp_q[2], gp_s[2]);
  // (RL12) expander 2 interrupt, falling edge
  assign irq_set[IRQ_EXP2]  = gp_alt_reg[4] & fell(gp_q[4], gp_s[4]);
  assign irq_set[IRQ_MDONE] = mdone_reg;
  assign irq_set[IRQ_MNACK] = mdone_reg & nack_reg;
  assign irq_set[IRQ_SADDR] = saddr_hit_reg;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_STRAP: reg_rdata <= {1'b0, slv_addr7, 1'b0, ee_addr7,
                                 slv_strap_reg, ee_strap_reg, 3'h0,
                                 lock_reg, cup_reg, cdn_reg, slow_reg,
                                 ref125_reg};
        // (RL16) fixed port roles
        REG_PORTCFG:  reg_rdata <= {16'h0000, LANES, DN_PORT_C,
                                    DN_PORT_B, UP_PORT};
        REG_GPIO_IN:  reg_rdata <= {24'h000000, gp_s};
        REG_GPIO_OUT: reg_rdata <= {24'h000000, gp_out_reg};
        REG_GPIO_DIR: reg_rdata <= {24'h000000, gp_dir_reg};
        REG_GPIO_ALT: reg_rdata <= {24'h000000, gp_alt_reg};
        REG_PORT_RST: reg_rdata <= {30'h00000000, port_rst_reg};
        REG_IRQ_STAT: reg_rdata <= {27'h0000000, irq_stat_reg};
        REG_IRQ_EN:   reg_rdata <= {27'h0000000, irq_en_reg};
        REG_MSTAT:    reg_rdata <= {16'h0000, rx_reg, 6'h00, nack_reg,
                                    mst_st != M_IDLE};
        default:      reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

/* swpin_chk.sv */
// Port-level checker for the strap and pin mux block
`timescale 1ns/1ns
module swpin_chk
  import swpin_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq,
  input wire logic        ref_clock_is_125,
  input wire logic [7:0]  ref_clock_mhz,
  input wire logic        shared_clock_down,
  input wire logic        shared_clock_up,
  input wire logic        master_bus_clock_oe_n,
  input wire logic        master_bus_data_oe_n,
  input wire logic [7:0]  gpio_out,
  input wire logic [7:0]  gpio_oe_n
);
  // ---------------------------------------------------------------
  // Shadow state
  // ---------------------------------------------------------------
  logic [7:0] alt_q;
  logic [1:0] rst_q;
  logic [4:0] age_q;
  logic       frame_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alt_q <= 8'h00;
      rst_q <= 2'h0;
    end else if (reg_wr && reg_addr == REG_GPIO_ALT) begin
      alt_q <= reg_wdata[7:0] & ALT_MASK;
    end else if (reg_wr && reg_addr == REG_PORT_RST) begin
      rst_q <= reg_wdata[1:0];
    end
  end
  // Saturates well past the strap window
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) age_q <= 5'h00;
    else if (age_q != 5'h1F) age_q <= age_q + 5'h01;
  end
  // Data edges with clock released mark start and stop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) frame_q <= 1'b0;
    else if (master_bus_clock_oe_n && $changed(master_bus_data_oe_n))
      frame_q <= !master_bus_data_oe_n;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    $fell(master_bus_data_oe_n) && master_bus_clock_oe_n;
  endsequence
  property p_ref_mhz;
    ref_clock_mhz == (ref_clock_is_125 ? REF_MHZ_HI : REF_MHZ_LO);
  endproperty
  property p_hold;
    age_q == 5'h1F |->
      $stable({ref_clock_is_125, shared_clock_down, shared_clock_up});
  endproperty
  property p_scl_frame;
    !master_bus_clock_oe_n |-> frame_q;
  endproperty
  property p_start_gap;
    s_start |-> master_bus_clock_oe_n [*8];
  endproperty
  property p_port_b;
    alt_q[0] && $stable(alt_q) && $stable(rst_q) |->
      !gpio_oe_n[0] && gpio_out[0] == !rst_q[0];
  endproperty
  property p_port_c;
    alt_q[1] && $stable(alt_q) && $stable(rst_q) |->
      !gpio_oe_n[1] && gpio_out[1] == !rst_q[1];
  endproperty
  property p_gpe;
    alt_q[7] && $stable(alt_q) && $stable(irq) |->
      !gpio_oe_n[7] && gpio_out[7] == !irq;
  endproperty
  property p_exp_in;
    $stable(alt_q) |-> (gpio_oe_n[2] || !alt_q[2])
      && (gpio_oe_n[4] || !alt_q[4]);
  endproperty
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_ref_mhz: assert property (p_ref_mhz)
    else $error("reference rate does not follow strap");
  a_hold: assert property (p_hold)
    else $error("captured strap moved after lock");
  a_scl_frame: assert property (p_scl_frame)
    else $error("master clock pulled outside a frame");
  a_start_gap: assert property (p_start_gap)
    else $error("clock pulled too soon after start");
  a_port_b: assert property (p_port_b)
    else $error("port b reset pin wrong");
  a_port_c: assert property (p_port_c)
    else $error("port c reset pin wrong");
  a_gpe: assert property (p_gpe)
    else $error("event pin does not follow irq");
  a_exp_in: assert property (p_exp_in)
    else $error("expander input pin driven");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside answer cycle");
endmodule
bind swpin_top swpin_chk u_chk (.*);

/* swpin_board.sv */
// Board model: pull-ups and expander interrupt lines on the pins
`timescale 1ns/1ns
module swpin_board (
  input  wire logic       master_bus_clock_oe_n,
  input  wire logic       master_bus_data_oe_n,
  input  wire logic [7:0] gpio_out,
  input  wire logic [7:0] gpio_oe_n,
  input  wire logic [1:0] exp_n,
  output logic            master_bus_clock_in,
  output logic            master_bus_data_in,
  output logic [7:0]      gpio_in
);
  // No device answers, so the ack slots read high
  assign master_bus_clock_in = master_bus_clock_oe_n;
  assign master_bus_data_in  = master_bus_data_oe_n;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      gpio_in[i] = gpio_oe_n[i] ? 1'b1 : gpio_out[i];
    end
    if (gpio_oe_n[2]) gpio_in[2] = exp_n[0];
    if (gpio_oe_n[4]) gpio_in[4] = exp_n[1];
  end
endmodule

/* swpin_bench.sv */
// Self-checking bench for the strap and pin mux block
`timescale 1ns/1ns
module swpin_bench;
  import swpin_pkg::*;
  logic        clk_sys, arst_n, reg_wr, reg_rd, irq;
  logic [7:0]  reg_addr, ref_clock_mhz, gpio_in, gpio_out, gpio_oe_n;
  logic [31:0] reg_wdata, reg_rdata;
  logic        ref_clock_freq_select, master_bus_slow_strap;
  logic [3:0]  eeprom_addr_strap, slave_addr_strap;
  logic        shared_clock_down_strap, shared_clock_up_strap;
  logic        ref_clock_is_125, shared_clock_down, shared_clock_up;
  logic        master_bus_clock_in, master_bus_clock_out;
  logic        master_bus_data_in, master_bus_data_out;
  logic        master_bus_clock_oe_n, master_bus_data_oe_n;
  logic        slave_bus_clock_out, slave_bus_clock_oe_n;
  logic        slave_bus_data_out, slave_bus_data_oe_n;
  logic        slave_bus_clock_in = 1'b1;
  logic        slave_bus_data_in = 1'b1;
  logic [1:0]  exp_n;
  int          failures = 0, checks_done = 0, falls = 0, n;
  swpin_top u_dut (.*);
  swpin_board u_board (.*);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(negedge master_bus_clock_oe_n) falls++;
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge clk_sys);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, arst_n} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ref_clock_freq_select = 1'b1;
    master_bus_slow_strap = 1'b0;
    eeprom_addr_strap = 4'h5;
    slave_addr_strap = 4'hA;
    shared_clock_down_strap = 1'b1;
    shared_clock_up_strap = 1'b0;
    exp_n = 2'h3;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rd(REG_STRAP, 32'h744A_A515);
    chk({24'h0, ref_clock_mhz}, 32'h7D);
    rd(REG_PORTCFG, 32'h8420);
    rd(8'h30, 32'h0);
    rd(REG_IRQ_CLR, 32'h0);
    // Late strap moves and writes are ignored
    ref_clock_freq_select <= 1'b0;
    shared_clock_up_strap <= 1'b1;
    wr(REG_STRAP, 32'hFFFF_FFFF);
    rd(REG_STRAP, 32'h744A_A515);
    $display("test straps done");
    wr(REG_GPIO_OUT, 32'h5A);
    wr(REG_GPIO_DIR, 32'hFF);
    repeat (6) @(posedge clk_sys);
    rd(REG_GPIO_IN, 32'h5A);
    wr(REG_GPIO_DIR, 32'h0);
    wr(REG_GPIO_ALT, 32'hFF);
    rd(REG_GPIO_ALT, 32'h97);
    wr(REG_PORT_RST, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk({24'h0, gpio_in}, 32'hFE);
    wr(REG_IRQ_EN, 32'h3);
    exp_n <= 2'h2;
    repeat (8) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, gpio_in[7]}, 32'h0);
    rd(REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_CLR, 32'h1);
    wr(REG_IRQ_EN, 32'h1);
    exp_n <= 2'h1;
    repeat (8) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd(REG_IRQ_STAT, 32'h2);
    wr(REG_IRQ_EN, 32'h2);
    #1 chk({31'h0, irq}, 32'h1);
    wr(REG_IRQ_CLR, 32'h1F);
    exp_n <= 2'h3;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    $display("test pins done");
    wr(REG_IRQ_EN, 32'h4);
    wr(REG_MCMD, 32'h2A);
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      final_report();
    end
    // Fast strap: 80 quarter ticks per frame
    chk({31'h0, n > 80*Q_FAST_CYC-6 && n < 80*Q_FAST_CYC+40}, 32'h1);
    chk(falls, 32'h13);
    rd(REG_IRQ_STAT, 32'hC);
    $display("test master done");
    final_report();
  end
endmodule
